// ### pkg/smp_pkg.sv
/*
  smp_pkg: constants and types shared by the serial-flash self-programming
  loader and its flash read engine.
  Assumes a 200 MHz pclk and one standard 24-bit-address read command.
*/
package smp_pkg;
  // clock figures
  localparam int CLK_HZ = 200_000_000; // pclk rate
  localparam int SCK_HZ = 20_000_000; // fixed flash clock rate
  localparam int HALF_CYC = CLK_HZ / (2 * SCK_HZ); // pclk cycles per half
  localparam int BOOT_WAIT = 8; // cycles for strap synchronisers to settle
  // flash command framing
  localparam logic [7:0] READ_CMD = 8'h03; // standard read
  localparam int CMD_BITS = 32; // command plus 24 address bits
  localparam int ADDR_W = 24; // flash address width
  localparam logic [23:0] DIR_BASE = 24'h000000; // directory location
  localparam logic [15:0] DIR_BYTES = 16'h0010; // two entries of 8 bytes
  localparam int ENTRY_BYTES = 8; // addr(4) len(2) version(2)
  // register map, byte addresses on apb
  localparam logic [11:0] REG_CTRL = 12'h000; // control
  localparam logic [11:0] REG_SERVICE = 12'h004; // service descriptor
  localparam logic [11:0] REG_STATUS = 12'h008; // status
  localparam logic [11:0] REG_AUTH_ADDR = 12'h00C; // bitstream address
  localparam logic [11:0] REG_VERSION = 12'h010; // programmed version
  localparam int CTRL_AU_BIT = 0; // auto update enable
  localparam logic AU_EN_RESET = 1'b0; // auto update off after reset
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_MASTER_BIT = 2;
  localparam int STAT_BLANK_BIT = 3;
  localparam int STAT_CODE_LSB = 8;
  // service descriptor layout
  localparam int DESC_W = 16;
  localparam int DESC_CMD_W = 7;
  localparam int DESC_OFF_LSB = 7;
  localparam logic [6:0] SVC_AUTH_BITS = 7'h23; // bitstream authentication
  localparam logic [6:0] SVC_AUTH_IMG = 7'h22; // image authentication
  localparam logic [6:0] SVC_UPDATE = 7'h46; // auto update
  localparam logic [6:0] SVC_IAP = 7'h42; // in-application programming
  // answer codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_ERR_IMAGE = 8'h01; // empty or missing image
  localparam logic [7:0] ST_ERR_CMD = 8'h02; // unknown or not allowed
  localparam logic [7:0] ST_ERR_BUSY = 8'h03; // request while busy
  typedef enum {OP_NONE, OP_AUTOPROG, OP_UPDATE, OP_IAP, OP_RECOVER,
                OP_AUTH_BITS, OP_AUTH_IMG} smp_op_t;
  typedef enum {S_BOOT, S_EVAL, S_IDLE, S_DIR, S_DIR_WAIT, S_CHOOSE,
                S_IMG, S_IMG_WAIT, S_FINISH} smp_state_t;
endpackage

// ### logic/smp_spi_read.sv
/*
  smp_spi_read: serial flash read engine, mode 3, fixed clock rate.
  Assumes miso is already synchronised into pclk by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module smp_spi_read #(
  parameter int HALF = smp_pkg::HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [smp_pkg::ADDR_W-1:0] addr,
  input wire logic [15:0] len,
  output logic [7:0] byte_data,
  output logic byte_valid,
  output logic done,
  output logic busy,
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  import smp_pkg::*;
  // the divider is fixed by elaboration, software cannot reach it
  if (HALF < 2 || HALF > 255) begin : g_bad_half
    $error("smp_spi_read: HALF out of range");
  end
  logic [7:0] div; // half-period counter
  logic first; // no bit shifted yet
  logic [19:0] nbit; // bits completed
  logic [19:0] total; // bits in the whole frame
  logic [31:0] out_sh; // command and address shifter
  logic [7:0] in_sh; // incoming byte shifter
  wire tick = (div == 8'(HALF - 1));
  wire last_bit = ((nbit + 20'd1) == total);
  wire data_ph = (nbit >= 20'(CMD_BITS));
  wire byte_end = data_ph && (nbit[2:0] == 3'h7);
  wire [7:0] next_in = {in_sh[6:0], miso};
  // one frame: select low, read command, address, then len data bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 8'h00;
      first <= 1'b1;
      nbit <= 20'h00000;
      total <= 20'h00000;
      out_sh <= 32'h00000000;
      in_sh <= 8'h00;
      byte_data <= 8'h00;
      byte_valid <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
      sck <= 1'b1; // mode 3 idles high
      cs_n <= 1'b1;
      mosi <= 1'b1;
    end else begin
      byte_valid <= 1'b0;
      done <= 1'b0;
      if (!busy) begin
        div <= 8'h00;
        if (start) begin
          busy <= 1'b1;
          cs_n <= 1'b0;
          first <= 1'b1;
          nbit <= 20'h00000;
          total <= 20'(CMD_BITS) + 20'({len, 3'b000});
          out_sh <= {READ_CMD, addr};
        end
      end else begin
        div <= tick ? 8'h00 : div + 8'h01; // fixed rate
        if (tick && sck) begin
          // sample just before the falling edge, shift out on it
          if (!first) begin
            in_sh <= next_in;
            nbit <= nbit + 20'd1;
          end
          if (!first && byte_end) begin
            byte_data <= next_in;
            byte_valid <= 1'b1;
          end
          if (!first && last_bit) begin
            cs_n <= 1'b1; // frame ends with clock high
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            sck <= 1'b0;
            mosi <= out_sh[31];
            out_sh <= {out_sh[30:0], 1'b0};
            first <= 1'b0;
          end
        end else if (tick) begin
          sck <= 1'b1; // rising edge, flash samples mosi
        end
      end
    end
  end
  // select high implies clock at its idle level
  a_idle_clock_high: assert property (@(posedge pclk) disable iff (!presetn)
    cs_n |-> sck) else $error("serial clock not idle high");
  // each low half lasts exactly HALF cycles at 200 MHz
  a_low_half_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sck) |-> (!sck) [*5] ##1 sck) else $error("bad half period");
  sequence s_first_bit;
    (!sck && !mosi) [*5];
  endsequence
  // the first command bit of the read code is a zero after one half
  a_read_cmd_start: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cs_n) |-> sck [*5] ##1 s_first_bit) else $error("bad cmd start");
endmodule // smp_spi_read
`default_nettype wire

// ### logic/smp_loader.sv
/*
  smp_loader: self-programming controller fetching images from serial
  flash, with an apb register slave for service requests.
  Assumes the nonvolatile state (blank, version, pending marks) is kept
  by a neighbour block on pclk, and that programming bytes are consumed
  at the flash byte rate with no back-pressure.
*/
`timescale 1ns/1ps
`default_nettype none
module smp_loader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_en_strap,
  input wire logic serial_role_strap,
  output logic flash_sck,
  output logic flash_sck_oe,
  output logic flash_cs_n,
  output logic flash_cs_n_oe,
  output logic flash_mosi,
  output logic flash_mosi_oe,
  input wire logic flash_miso,
  input wire logic nv_blank,
  input wire logic [15:0] nv_version,
  input wire logic nv_prog_pending,
  input wire logic nv_mem_phase,
  output logic [7:0] prog_data,
  output logic prog_valid,
  output logic nv_pending_set,
  output logic nv_pending_clr,
  output logic nv_version_wr,
  output logic [15:0] nv_version_new,
  output logic restart_req,
  output logic ext_cmd_block
);
  import smp_pkg::*;
  localparam int NSYNC = 3; // miso, role strap, enable strap
  // pin synchronisers, a change counts when stages two and three agree
  logic [NSYNC-1:0] sync1; // first stage, read only by sync2
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt; // agreed pin levels
  wire [NSYNC-1:0] pin_raw = {spi_en_strap, serial_role_strap, flash_miso};
  genvar gi;
  for (gi = 0; gi < NSYNC; gi++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1[gi] <= 1'b0;
        sync2[gi] <= 1'b0;
        sync3[gi] <= 1'b0;
        filt[gi] <= 1'b0;
      end else begin
        sync1[gi] <= pin_raw[gi];
        sync2[gi] <= sync1[gi];
        sync3[gi] <= sync2[gi];
        if (sync2[gi] == sync3[gi]) begin
          filt[gi] <= sync3[gi];
        end
      end
    end
  end
  wire miso_s = filt[0];
  // state
  smp_state_t state; // main sequence
  smp_op_t op; // operation in flight
  logic [3:0] boot_cnt; // strap settle counter
  logic master_ok; // both straps one, caught after reset
  logic au_en; // auto update enable
  logic [15:0] desc; // last service descriptor
  logic [23:0] auth_addr; // bitstream location for authentication
  logic [7:0] last_status; // answer code
  logic svc_done; // sticky answer flag
  logic from_svc; // operation came from a request
  logic [3:0] dir_idx; // directory byte index
  logic [7:0] dir_mem [0:DIR_BYTES-1]; // directory bytes
  logic [ADDR_W-1:0] ent_addr [0:1]; // image addresses
  logic [15:0] ent_len [0:1]; // image lengths
  logic [15:0] ent_ver [0:1]; // image versions
  // spi engine wires
  logic spi_bv, spi_done, spi_busy;
  logic [7:0] spi_byte;
  // directory entry decode, big-endian fields
  for (gi = 0; gi < 2; gi++) begin : g_ent
    localparam int B = gi * ENTRY_BYTES;
    assign ent_addr[gi] = {dir_mem[B+1], dir_mem[B+2], dir_mem[B+3]};
    assign ent_len[gi] = {dir_mem[B+4], dir_mem[B+5]};
    assign ent_ver[gi] = {dir_mem[B+6], dir_mem[B+7]};
  end
  // image selection: newest of two, or the index from the descriptor
  wire newer = (ent_ver[1] > ent_ver[0]);
  wire by_index = (op == OP_IAP) || (op == OP_AUTH_IMG);
  wire bad_index = by_index && (desc[14:8] != 7'h00);
  wire sel = by_index ? desc[DESC_OFF_LSB] : newer;
  wire [ADDR_W-1:0] sel_addr = (op == OP_AUTH_BITS) ? auth_addr
                                                    : ent_addr[sel];
  wire [15:0] sel_len = ent_len[sel];
  wire [15:0] sel_ver = ent_ver[sel];
  wire do_prog = (op == OP_AUTOPROG) || (op == OP_UPDATE) ||
                 (op == OP_IAP) || (op == OP_RECOVER);
  wire same_ver = (op == OP_UPDATE) && (sel_ver == nv_version);
  wire busy = (state != S_IDLE) && (state != S_BOOT) && (state != S_EVAL);
  // descriptor fields
  wire [DESC_CMD_W-1:0] wr_cmd = pwdata[DESC_CMD_W-1:0];
  wire cmd_known = (wr_cmd == SVC_AUTH_BITS) || (wr_cmd == SVC_AUTH_IMG) ||
                   (wr_cmd == SVC_UPDATE) || (wr_cmd == SVC_IAP);
  // apb decode, zero wait states
  wire acc = psel && penable;
  wire wr_en = acc && pwrite;
  wire hit = (paddr == REG_CTRL) || (paddr == REG_SERVICE) ||
             (paddr == REG_STATUS) || (paddr == REG_AUTH_ADDR) ||
             (paddr == REG_VERSION);
  wire wr_svc = wr_en && (paddr == REG_SERVICE);
  wire svc_idle = (state == S_IDLE);
  wire svc_go = wr_svc && svc_idle && master_ok && cmd_known;
  wire svc_rej = wr_svc && !svc_go;
  wire done_clr = wr_en && (paddr == REG_STATUS) && pwdata[STAT_DONE_BIT];
  wire done_set = ((state == S_FINISH) && from_svc) || svc_rej;
  wire [31:0] stat_word = {16'h0000, last_status, 4'h0, nv_blank, master_ok,
                           svc_done, busy};
  wire [31:0] rd_word = (paddr == REG_CTRL) ? {31'h0, au_en} :
                        (paddr == REG_SERVICE) ? {16'h0000, desc} :
                        (paddr == REG_STATUS) ? stat_word :
                        (paddr == REG_AUTH_ADDR) ? {8'h00, auth_addr} :
                        (paddr == REG_VERSION) ? {16'h0000, nv_version} :
                        32'h00000000;
  assign pready = 1'b1; // same slave answers the bridge bus too
  assign pslverr = acc && !hit;
  // outputs enabled only in master configuration
  assign flash_sck_oe = master_ok;
  assign flash_cs_n_oe = master_ok;
  assign flash_mosi_oe = master_ok;
  // external jtag and slave commands held off while a job runs
  assign ext_cmd_block = busy;
  // flash engine start: directory then image, one cycle per request
  wire spi_start = (state == S_DIR) || (state == S_IMG);
  wire [ADDR_W-1:0] spi_addr = (state == S_DIR) ? DIR_BASE : sel_addr;
  wire [15:0] spi_len = (state == S_DIR) ? DIR_BYTES : sel_len;
  smp_spi_read u_spi (
    .pclk(pclk),
    .presetn(presetn),
    .start(spi_start),
    .addr(spi_addr),
    .len(spi_len),
    .byte_data(spi_byte),
    .byte_valid(spi_bv),
    .done(spi_done),
    .busy(spi_busy),
    .sck(flash_sck),
    .cs_n(flash_cs_n),
    .mosi(flash_mosi),
    .miso(miso_s)
  );
  // registers software writes; read data latched in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      au_en <= AU_EN_RESET; // off until the design turns it on
      auth_addr <= 24'h000000;
      prdata <= 32'h00000000;
      svc_done <= 1'b0;
    end else begin
      if (wr_en && paddr == REG_CTRL) au_en <= pwdata[CTRL_AU_BIT];
      if (wr_en && paddr == REG_AUTH_ADDR) auth_addr <= pwdata[23:0];
      if (psel && !penable) prdata <= rd_word;
      // a new answer wins over a clear in the same cycle
      svc_done <= done_set || (svc_done && !done_clr);
    end
  end
  // directory capture
  always_ff @(posedge pclk) begin
    if (state == S_DIR_WAIT && spi_bv) dir_mem[dir_idx] <= spi_byte;
  end
  // main sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_BOOT;
      op <= OP_NONE;
      boot_cnt <= 4'h0;
      master_ok <= 1'b0;
      desc <= 16'h0000;
      last_status <= ST_OK;
      from_svc <= 1'b0;
      dir_idx <= 4'h0;
      prog_data <= 8'h00;
      prog_valid <= 1'b0;
      nv_pending_set <= 1'b0;
      nv_pending_clr <= 1'b0;
      nv_version_wr <= 1'b0;
      nv_version_new <= 16'h0000;
      restart_req <= 1'b0;
    end else begin
      prog_valid <= 1'b0;
      nv_pending_set <= 1'b0;
      nv_pending_clr <= 1'b0;
      nv_version_wr <= 1'b0;
      restart_req <= 1'b0;
      // a refused write must not retarget the job in flight
      if (svc_go) desc <= pwdata[DESC_W-1:0];
      if (svc_rej) last_status <= svc_idle ? ST_ERR_CMD : ST_ERR_BUSY;
      case (state)
        S_BOOT: begin
          // straps are caught once after reset, never switched live
          boot_cnt <= boot_cnt + 4'h1;
          if (boot_cnt == 4'(BOOT_WAIT - 1)) begin
            master_ok <= filt[2] && filt[1];
            state <= S_EVAL;
          end
        end
        S_EVAL: begin
          // start-up checks run only in master configuration
          from_svc <= 1'b0;
          state <= S_DIR;
          if (!master_ok) begin
            state <= S_IDLE;
          end else if (nv_prog_pending && !nv_mem_phase) begin
            op <= OP_RECOVER;
          end else begin
            nv_pending_clr <= nv_prog_pending; // boot normally
            if (nv_blank) begin
              op <= OP_AUTOPROG;
            end else if (au_en) begin
              op <= OP_UPDATE;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_IDLE: begin
          if (svc_go) begin
            from_svc <= 1'b1;
            state <= S_DIR;
            case (wr_cmd)
              SVC_AUTH_BITS: op <= OP_AUTH_BITS;
              SVC_AUTH_IMG: op <= OP_AUTH_IMG;
              SVC_UPDATE: op <= OP_UPDATE;
              default: op <= OP_IAP; // only on request
            endcase
          end
        end
        S_DIR: begin
          dir_idx <= 4'h0;
          state <= S_DIR_WAIT;
        end
        S_DIR_WAIT: begin
          if (spi_bv) dir_idx <= dir_idx + 4'h1;
          if (spi_done) state <= S_CHOOSE;
        end
        S_CHOOSE: begin
          if (sel_len == 16'h0000 || bad_index) begin
            last_status <= ST_ERR_IMAGE;
            state <= S_FINISH;
          end else if (same_ver) begin
            last_status <= ST_OK; // nothing to do
            state <= S_FINISH;
          end else begin
            nv_pending_set <= do_prog;
            state <= S_IMG;
          end
        end
        S_IMG: begin
          state <= S_IMG_WAIT;
        end
        S_IMG_WAIT: begin
          // runs to the end, nothing aborts it
          prog_data <= spi_byte;
          prog_valid <= spi_bv && do_prog;
          if (spi_done) begin
            nv_pending_clr <= do_prog;
            nv_version_wr <= do_prog;
            nv_version_new <= sel_ver;
            restart_req <= do_prog;
            last_status <= ST_OK;
            state <= S_FINISH;
          end
        end
        S_FINISH: begin
          op <= OP_NONE;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  sequence s_eval_recover;
    (state == S_EVAL) && master_ok && nv_prog_pending && !nv_mem_phase;
  endsequence
  a_no_prog_wo_strap: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_DIR) |-> master_ok) else $error("flash used without straps");
  a_blank_autoprog: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_EVAL) && master_ok && !nv_prog_pending && nv_blank |=>
    (op == OP_AUTOPROG) && (state == S_DIR)) else $error("no auto program");
  a_recover_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_eval_recover |=> (op == OP_RECOVER) ##1 (state == S_DIR_WAIT))
    else $error("no recovery");
  a_mem_no_recover: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_EVAL) && nv_prog_pending && nv_mem_phase && master_ok |=>
    (op != OP_RECOVER) && nv_pending_clr) else $error("bad recovery");
  a_same_ver_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_CHOOSE) && same_ver && (sel_len != 16'h0000) && !bad_index |=>
    (state == S_FINISH) && !nv_pending_set) else $error("needless update");
  a_atomic_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_IMG_WAIT) |-> ext_cmd_block && !svc_go) else $error("job preempted");
  a_svc_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_FINISH) && from_svc |=> svc_done) else $error("no answer");
  a_iap_only_req: assert property (@(posedge pclk) disable iff (!presetn)
    (op == OP_IAP) |-> from_svc) else $error("unrequested iap");
  a_au_off_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(boot_cnt == 4'h1) |-> !au_en) else $error("auto update on");
endmodule // smp_loader
`default_nettype wire

// ### dv/smp_flash_model.sv
/* smp_flash_model: serial flash partner, mode 3 reads only.
   Assumes the loader drives sck, cs_n (pulled up when released), mosi. */
`timescale 1ns/1ps
`default_nettype none
module smp_flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [31:0] hdr
);
  logic [7:0] mem [256]; // only the low 8 address bits decode
  int cnt; // rising clock edges seen in this frame
  int d; // data bit index after the header
  // directory of two entries, then two small images
  initial begin
    miso = 1'b1;
    hdr = '0;
    cnt = 0;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[3] = 8'h40;
    mem[5] = 8'h04;
    mem[7] = 8'h02;
    mem[11] = 8'h50;
    mem[13] = 8'h04;
    mem[15] = 8'h03;
    for (int i = 0; i < 4; i++) begin
      mem[8'h40 + i] = 8'hA0 + 8'(i);
      mem[8'h50 + i] = 8'hB0 + 8'(i);
    end
  end
  // command and address are taken on the rising edge
  always @(posedge sck) begin
    if (!cs_n && cnt < 32) hdr = {hdr[30:0], mosi};
    if (!cs_n) cnt = cnt + 1;
  end
  // data leaves on the falling edge, msb first
  always @(negedge sck) begin
    d = cnt - 32;
    if (!cs_n && cnt >= 32) miso = mem[8'(hdr[7:0] + d / 8)][3'(7 - d % 8)];
  end
  always @(negedge cs_n) cnt = 0;
  // a released line shows the inverse, so a stale bit never passes
  always @(posedge cs_n) miso = ~miso;
endmodule // smp_flash_model
`default_nettype wire

// ### dv/smp_loader_tb_top.sv
/* smp_loader_tb_top: self-checking bench for the loader.
   Assumes smp_flash_model on the flash pins and straps held by the bench. */
`timescale 1ns/1ps
`default_nettype none
module smp_loader_tb_top;
  import smp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, hdr;
  logic pready, pslverr, sck, sck_oe, cs_n, cs_oe, mosi, mosi_oe, miso;
  // straps are plain board levels, never driven by the device
  logic en_strap = 1, role_strap = 1, blank = 1, pend = 0, mphase = 0;
  logic [15:0] ver = '0, vnew, vcap;
  logic [7:0] pdata, lastb;
  logic pvalid, pset, pclr, vwr, rst_req, blk, sck_q;
  int num_errors = 0, checked = 0, cyc = 0, nprog = 0, lowc = 0, low_len;
  int npul = 0; // pending set 1, pending clear 16, restart 256 per pulse
  wire cs_w = cs_oe ? cs_n : 1'b1; // select line has a pull-up
  always #2.5 pclk = ~pclk;
  smp_loader DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spi_en_strap(en_strap), .serial_role_strap(role_strap),
    .flash_sck(sck), .flash_sck_oe(sck_oe), .flash_cs_n(cs_n),
    .flash_cs_n_oe(cs_oe), .flash_mosi(mosi), .flash_mosi_oe(mosi_oe),
    .flash_miso(miso), .nv_blank(blank), .nv_version(ver),
    .nv_prog_pending(pend), .nv_mem_phase(mphase), .prog_data(pdata),
    .prog_valid(pvalid), .nv_pending_set(pset), .nv_pending_clr(pclr),
    .nv_version_wr(vwr), .nv_version_new(vnew), .restart_req(rst_req),
    .ext_cmd_block(blk));
  smp_flash_model flash (.sck(sck), .cs_n(cs_w), .mosi(mosi), .miso(miso),
    .hdr(hdr));
  // byte count, clock-low length, version capture and hang limit
  always @(posedge pclk) begin
    if (pvalid === 1'b1) nprog = nprog + 1;
    if (pvalid === 1'b1) lastb = pdata;
    if (vwr === 1'b1) vcap = vnew;
    if (pset === 1'b1) npul = npul + 1;
    if (pclr === 1'b1) npul = npul + 16;
    if (rst_req === 1'b1) npul = npul + 256;
    if (sck && !sck_q) low_len = lowc;
    lowc = sck ? 0 : lowc + 1;
    sck_q = sck;
    cyc = cyc + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the job is over; rd keeps the status word
  task automatic idle();
    int n = 0;
    do begin
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_STATUS, '0);
      n = n + 1;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (rd[STAT_BUSY_BIT] !== 1'b0) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t job never finished", $time);
      finish_test();
    end
  endtask
  task automatic svc(input logic [15:0] desc);
    apb(1'b1, REG_SERVICE, {16'h0000, desc});
    idle();
  endtask
  task automatic do_reset(input logic b, p, m, s);
    presetn <= 1'b0;
    blank <= b;
    pend <= p;
    mphase <= m;
    role_strap <= s;
    repeat (3) @(posedge pclk);
    chk(32'({sck, cs_n, mosi, sck_oe, cs_oe, mosi_oe, blk}), 32'h70);
    nprog = 0;
    npul = 0;
    vcap = '0;
    presetn <= 1'b1;
    repeat (14) @(posedge pclk);
    idle();
  endtask
  task automatic t_boot();
    do_reset(1'b1, 1'b0, 1'b0, 1'b1);
    chk(nprog, 4);
    chk(lastb, 8'hB3);
    chk(vcap, 16'h0003);
    chk(hdr, 32'h03000050);
    chk(low_len, HALF_CYC);
    chk(npul, 32'h111);
  endtask
  task automatic t_update();
    ver <= 16'h0003;
    do_reset(1'b0, 1'b0, 1'b0, 1'b1);
    chk(nprog, 0);
    apb(1'b0, REG_CTRL, '0);
    chk(rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    svc({9'h000, SVC_UPDATE});
    chk(nprog, 0);
    ver <= 16'h0002;
    svc({9'h000, SVC_UPDATE});
    chk(nprog, 4);
    chk(npul, 32'h111);
    chk(vcap, 16'h0003);
    apb(1'b0, REG_VERSION, '0);
    chk(rd, 32'h2);
  endtask
  task automatic t_iap();
    nprog = 0;
    svc({9'h000, SVC_IAP});
    chk(lastb, 8'hA3);
    svc({9'h001, SVC_IAP});
    chk(lastb, 8'hB3);
    svc({9'h002, SVC_IAP});
    chk(rd[15:8], ST_ERR_IMAGE);
    apb(1'b1, REG_SERVICE, 32'(SVC_IAP));
    repeat (3) @(posedge pclk);
    chk(blk, 1'b1);
    apb(1'b1, REG_SERVICE, 32'(SVC_UPDATE));
    apb(1'b0, REG_STATUS, '0);
    chk(rd[15:8], ST_ERR_BUSY);
    idle();
    chk(nprog, 12);
  endtask
  task automatic t_auth();
    apb(1'b1, REG_AUTH_ADDR, 32'h40);
    svc({9'h000, SVC_AUTH_BITS});
    chk(rd[15:8], ST_OK);
    chk(hdr, 32'h03000040);
    svc({9'h001, SVC_AUTH_IMG});
    chk(hdr, 32'h03000050);
    svc(16'h007F);
    chk(rd[15:8], ST_ERR_CMD);
    chk(rd[3:0], 4'h6);
    apb(1'b1, REG_STATUS, 32'h2);
    apb(1'b0, REG_STATUS, '0);
    chk(rd[3:0], 4'h4);
    chk(nprog, 12);
    apb(1'b0, 12'h020, '0);
    chk(perr, 1'b1);
  endtask
  task automatic t_recover();
    do_reset(1'b0, 1'b1, 1'b0, 1'b1);
    chk(nprog, 4);
    chk(npul, 32'h111);
    do_reset(1'b0, 1'b1, 1'b1, 1'b1);
    chk(nprog, 0);
    chk(npul, 32'h010);
  endtask
  task automatic t_strap();
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    chk(nprog, 0);
    chk(32'({sck_oe, cs_oe, mosi_oe}), 32'h0);
    svc({9'h000, SVC_IAP});
    chk(rd[15:8], ST_ERR_CMD);
    en_strap <= 1'b0;
    do_reset(1'b1, 1'b0, 1'b0, 1'b1);
    chk(nprog, 0);
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    t_boot();
    t_update();
    t_iap();
    t_auth();
    t_recover();
    t_strap();
    finish_test();
  end
endmodule // smp_loader_tb_top
`default_nettype wire
